//--- core/instr_exec_pkg.sv
package instr_exec_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_INSTR     = 8'h00;
    localparam logic [7:0] OFS_BANK_SEL  = 8'h04;
    localparam logic [7:0] OFS_FLAGS     = 8'h08;
    localparam logic [7:0] OFS_DATA_ADDR = 8'h0C;
    localparam logic [7:0] OFS_DATA      = 8'h10;
    localparam logic [7:0] OFS_WD_COUNT  = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;
    localparam logic [7:0] OFS_WAKE      = 8'h20;

    // flags register fields
    localparam int FLG_PWR_DOWN = 0;
    localparam int FLG_TIMEOUT  = 1;
    localparam int FLG_SLEEP    = 2;
    localparam int FLG_BUSY     = 3;

    // interrupt status fields
    localparam int IRQ_ONES  = 0;
    localparam int IRQ_SLEEP = 1;
    localparam int IRQ_WAKE  = 2;
    localparam int IRQ_ILL   = 3;
    localparam int IRQ_W     = 4;

    // reset values
    localparam logic        PWR_DOWN_RST = 1'b1;
    localparam logic        TIMEOUT_RST  = 1'b1;
    localparam logic [3:0]  BANK_RST     = 4'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
    localparam logic [15:0] INSTR_RST    = 16'h0000;

    // instruction encodings
    localparam logic [6:0]  ONES_OPC     = 7'h34;
    localparam logic [15:0] SLEEP_WORD   = 16'h0003;
    localparam logic [7:0]  ALL_ONES     = 8'hFF;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  ACCESS_LO_BK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BK = 4'hF;

    // watchdog sizing
    localparam logic [7:0]  WD_PS_MAX    = 8'hFF;
    localparam logic [15:0] WD_LIMIT_DEF = 16'h0100;

    // bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

    // decoded instruction fields
    typedef struct packed {
        logic       is_ones;
        logic       is_sleep;
        logic       bank_bit;
        logic [7:0] faddr;
    } dec_type;

    // captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_addr_type;

    // split one program word into its fields
    function automatic dec_type decode(input logic [15:0] w);
        dec_type d;
        d.is_ones  = (w[15:9] == ONES_OPC);
        d.is_sleep = (w == SLEEP_WORD);
        d.bank_bit = w[8];
        d.faddr    = w[7:0];
        return d;
    endfunction : decode

    // full data-memory address from bank bit, bank select and offset
    function automatic logic [11:0] bank_addr(input logic bank_bit,
                                              input logic [3:0] bank_sel,
                                              input logic [7:0] f);
        logic [3:0] bk;
        bk = bank_bit ? bank_sel : ((f < ACCESS_SPLIT) ? ACCESS_LO_BK : ACCESS_HI_BK);
        return {bk, f};
    endfunction : bank_addr

endpackage : instr_exec_pkg

//--- core/instr_decode.sv
`timescale 1ns/1ps
module instr_decode (
    input  wire logic [15:0]                  word_i,
    input  wire logic [3:0]                   bank_sel_i,
    output instr_exec_pkg::dec_type           dec_o,
    output logic [11:0]                       target_o
);
    // field split of the current word
    assign dec_o    = instr_exec_pkg::decode(word_i);
    assign target_o = instr_exec_pkg::bank_addr(dec_o.bank_bit, bank_sel_i, dec_o.faddr);
endmodule : instr_decode

//--- core/watchdog_timer.sv
`timescale 1ns/1ps
module watchdog_timer (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        clear_i,   // zero count and postscaler
    input  wire logic [15:0] limit_i,   // count at which it times out
    output logic [15:0]      count_o,
    output logic             timeout_o  // one-cycle pulse
);
    logic [7:0]  ps_r;       // postscaler
    logic [15:0] cnt_r;      // main count
    wire         ps_wrap  = (ps_r == instr_exec_pkg::WD_PS_MAX);
    wire         cnt_hit  = ps_wrap && (cnt_r == limit_i);

    // postscaler then count; clear beats everything
    always_ff @(posedge clk_i) begin
        if (!nrst_i || clear_i) begin
            ps_r      <= 8'h00;
            cnt_r     <= 16'h0000;
            timeout_o <= 1'b0;
        end else begin
            ps_r      <= ps_r + 8'h01;
            cnt_r     <= cnt_hit ? 16'h0000 : (ps_wrap ? cnt_r + 16'h0001 : cnt_r);
            timeout_o <= cnt_hit;
        end
    end
    assign count_o = cnt_r;
endmodule : watchdog_timer

//--- core/instr_exec_core.sv
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module instr_exec_core #(
    parameter logic [15:0] WD_LIMIT = instr_exec_pkg::WD_LIMIT_DEF
) (
    input  wire logic        CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             IRQ_O,
    output logic             OSC_RUN_O,
    output logic             SLEEP_O
);

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_Q1    = 6'b000010,
        ST_Q2    = 6'b000100,
        ST_Q3    = 6'b001000,
        ST_Q4    = 6'b010000,
        ST_SLEEP = 6'b100000
    } state_type;

    state_type                     state_r, state_nxt;   // current phase
    logic [15:0]                   instr_r;              // word being run
    logic [3:0]                    bank_r;               // bank select register
    logic [11:0]                   data_addr_r;          // software memory pointer
    logic [11:0]                   target_r;             // latched in decode phase
    logic                          power_down_flag_r;    // cleared by sleep
    logic                          timeout_flag_r;       // set by sleep, cleared by watchdog wake
    logic [instr_exec_pkg::IRQ_W-1:0] stat_r, mask_r;    // sticky events, mask
    logic [7:0]                    mem [0:4095];         // banked data registers
    instr_exec_pkg::ahb_addr_type  ap_r;                 // pending data phase
    logic                          rd_wait_r;            // read wait state done
    logic [31:0]                   rdata_r;              // read data flop
    instr_exec_pkg::dec_type       dec;                  // decoded word
    logic [11:0]                   target;               // decoded address
    logic [15:0]                   wd_count;             // watchdog count
    logic                          wd_tmo;               // watchdog timeout pulse
    logic [24:0]                   sleep_cyc_r;          // cycles spent asleep

    ////////////////////////////////////////////////////////////////////////////
    // decode and watchdog
    instr_decode i_instr_decode (
        .word_i     (instr_r),
        .bank_sel_i (bank_r),
        .dec_o      (dec),
        .target_o   (target)
    );

    // phase and sleep decode
    wire q4_sleep = (state_r == ST_Q4) && dec.is_sleep;
    wire q4_ones  = (state_r == ST_Q4) && dec.is_ones;
    wire q4_ill   = (state_r == ST_Q4) && !dec.is_ones && !dec.is_sleep;
    wire sleeping = (state_r == ST_SLEEP);
    wire busy     = !(state_r == ST_IDLE) && !sleeping;
    wire wd_wake  = sleeping && wd_tmo;

    watchdog_timer i_watchdog_timer (
        .clk_i     (CLK_I),
        .nrst_i    (NRST_I),
        .clear_i   (q4_sleep),
        .limit_i   (WD_LIMIT),
        .count_o   (wd_count),
        .timeout_o (wd_tmo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode; writes take no wait, reads take one
    wire ap_take  = HSEL_I && HREADY_I && (HTRANS_I == instr_exec_pkg::HTRANS_NONSEQ
                                        || HTRANS_I == instr_exec_pkg::HTRANS_SEQ);
    wire wr_now   = ap_r.valid && ap_r.write;
    wire rd_now   = ap_r.valid && !ap_r.write;
    wire wr_instr = wr_now && (ap_r.addr == instr_exec_pkg::OFS_INSTR) && !busy && !sleeping;
    wire wr_bank  = wr_now && (ap_r.addr == instr_exec_pkg::OFS_BANK_SEL);
    wire wr_daddr = wr_now && (ap_r.addr == instr_exec_pkg::OFS_DATA_ADDR);
    wire wr_data  = wr_now && (ap_r.addr == instr_exec_pkg::OFS_DATA) && !busy;
    wire wr_stat  = wr_now && (ap_r.addr == instr_exec_pkg::OFS_IRQ_STAT);
    wire wr_mask  = wr_now && (ap_r.addr == instr_exec_pkg::OFS_IRQ_MASK);
    wire wr_wake  = wr_now && (ap_r.addr == instr_exec_pkg::OFS_WAKE) && HWDATA_I[0];
    wire sw_wake  = sleeping && wr_wake;

    // read mux; unmapped words read zero
    logic [31:0] rd_mux;
    assign rd_mux =
        (ap_r.addr == instr_exec_pkg::OFS_INSTR)     ? {16'h0000, instr_r} :
        (ap_r.addr == instr_exec_pkg::OFS_BANK_SEL)  ? {28'h000_0000, bank_r} :
        (ap_r.addr == instr_exec_pkg::OFS_FLAGS)     ? {28'h000_0000, busy, sleeping,
                                                         timeout_flag_r, power_down_flag_r} :
        (ap_r.addr == instr_exec_pkg::OFS_DATA_ADDR) ? {20'h0_0000, data_addr_r} :
        (ap_r.addr == instr_exec_pkg::OFS_DATA)      ? {24'h00_0000, mem[data_addr_r]} :
        (ap_r.addr == instr_exec_pkg::OFS_WD_COUNT)  ? {16'h0000, wd_count} :
        (ap_r.addr == instr_exec_pkg::OFS_IRQ_STAT)  ? {28'h000_0000, stat_r} :
        (ap_r.addr == instr_exec_pkg::OFS_IRQ_MASK)  ? {28'h000_0000, mask_r} :
                                                       32'h0000_0000;

    // ready drops only in the first cycle of a read data phase
    assign HREADYOUT_O = !(rd_now && !rd_wait_r);
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = rdata_r;

    // address phase capture
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ap_r <= '0;
        end else if (HREADYOUT_O) begin
            ap_r <= '{valid: ap_take, write: HWRITE_I, addr: HADDR_I[7:0]};
        end
    end

    // read wait flag and data flop
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rd_wait_r <= 1'b0;
            rdata_r   <= 32'h0000_0000;
        end else begin
            rd_wait_r <= rd_now && !rd_wait_r;
            if (rd_now && !rd_wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer: one program word, Q1..Q4, then idle or sleep
    // four-phase cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  state_nxt = wr_instr ? ST_Q1 : ST_IDLE;
            ST_Q1:    state_nxt = ST_Q2;   // decode
            ST_Q2:    state_nxt = ST_Q3;   // operand read
            ST_Q3:    state_nxt = ST_Q4;   // process
            ST_Q4:    state_nxt = dec.is_sleep ? ST_SLEEP : ST_IDLE;
            ST_SLEEP: state_nxt = (wd_wake || sw_wake) ? ST_IDLE : ST_SLEEP;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // oscillator gate; the watchdog keeps its own time during sleep
    assign OSC_RUN_O = !sleeping;
    assign SLEEP_O   = sleeping;

    ////////////////////////////////////////////////////////////////////////////
    // software registers; a new word is only taken while idle
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            instr_r     <= instr_exec_pkg::INSTR_RST;
            bank_r      <= instr_exec_pkg::BANK_RST;
            data_addr_r <= 12'h000;
            mask_r      <= instr_exec_pkg::MASK_RST;
        end else begin
            if (wr_instr) instr_r     <= HWDATA_I[15:0];
            if (wr_bank)  bank_r      <= HWDATA_I[3:0];
            if (wr_daddr) data_addr_r <= HWDATA_I[11:0];
            if (wr_mask)  mask_r      <= HWDATA_I[instr_exec_pkg::IRQ_W-1:0];
        end
    end

    // latch bank-resolved target in decode phase
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            target_r <= 12'h000;
        end else if (state_r == ST_Q1) begin
            target_r <= target;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (q4_ones) begin
            mem[target_r] <= instr_exec_pkg::ALL_ONES;
        end else if (wr_data) begin
            mem[data_addr_r] <= HWDATA_I[7:0];
        end
    end

    // status flags; watchdog wake lands after sleep so never collides
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            power_down_flag_r <= instr_exec_pkg::PWR_DOWN_RST;
            timeout_flag_r    <= instr_exec_pkg::TIMEOUT_RST;
        end else if (q4_sleep) begin
            power_down_flag_r <= 1'b0;
            timeout_flag_r    <= 1'b1;
        end else if (wd_wake) begin
            timeout_flag_r    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky events; a new event beats a same-cycle write-one clear
    wire [instr_exec_pkg::IRQ_W-1:0] events = {q4_ill, wd_wake || sw_wake, q4_sleep, q4_ones};
    wire [instr_exec_pkg::IRQ_W-1:0] w1c    = wr_stat ? HWDATA_I[instr_exec_pkg::IRQ_W-1:0]
                                                      : 4'h0;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            stat_r <= 4'h0;
        end else begin
            stat_r <= (stat_r & ~w1c) | events;
        end
    end

    assign IRQ_O = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // sleep length for the checks; a timeout wake needs a whole watchdog period,
    // so a leftover postscaler count shows up as a short sleep
    wire [24:0] sleep_full = {1'b0, WD_LIMIT, 8'h00}
                           + {17'h0_0000, instr_exec_pkg::WD_PS_MAX} + 25'h000_0001;

    // restart on sleep entry, count every cycle asleep
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || q4_sleep) begin
            sleep_cyc_r <= 25'h000_0000;
        end else if (sleeping) begin
            sleep_cyc_r <= sleep_cyc_r + 25'h000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence four_phases_s;
        (state_r == ST_Q1) ##1 (state_r == ST_Q2) ##1 (state_r == ST_Q3)
            ##1 (state_r == ST_Q4);
    endsequence

    sequence sleep_done_s;
        sleeping && !OSC_RUN_O && SLEEP_O;
    endsequence

    // read data phase: one low cycle, then ready
    sequence read_wait_s;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence

    ones_write_a: assert property (q4_ones |=> mem[$past(target_r)] == 8'hFF)
        else $error("all-ones write missing");
    access_bank_a: assert property ((state_r == ST_Q1) && !dec.bank_bit |=>
        target_r[11:8] == ((instr_r[7:0] < 8'h80) ? 4'h0 : 4'hF))
        else $error("access bank not used");
    bank_sel_a: assert property ((state_r == ST_Q1) && dec.bank_bit |=>
        target_r[11:8] == $past(bank_r))
        else $error("bank select not used");
    sleep_entry_a: assert property (q4_sleep |=> sleep_done_s)
        else $error("sleep not entered");
    pwr_down_clear_a: assert property (q4_sleep |=> !power_down_flag_r)
        else $error("power-down flag not cleared");
    timeout_set_a: assert property (q4_sleep |=>
        timeout_flag_r ##1 (timeout_flag_r || !sleeping))
        else $error("timeout flag not set");
    wd_clear_a: assert property (q4_sleep |=> wd_count == 16'h0000)
        else $error("watchdog not cleared");
    wd_wake_a: assert property (wd_wake |=> !timeout_flag_r && (state_r == ST_IDLE))
        else $error("watchdog wake wrong");
    one_cycle_a: assert property ($rose(state_r == ST_Q1) |-> four_phases_s)
        else $error("instruction not four phases");

    // a timeout wake comes exactly one full watchdog period after entry
    wake_time_a: assert property (wd_wake |-> sleep_cyc_r == sleep_full)
        else $error("watchdog wake at wrong time");
    // asleep means asleep until one of the two wake sources fires
    sleep_hold_a: assert property (sleeping && !wd_wake && !sw_wake |=> sleep_done_s)
        else $error("left sleep with no wake");
    // a software wake must leave the timeout flag as it was
    soft_wake_a: assert property (sw_wake && !wd_wake |=> (state_r == ST_IDLE)
        && $stable(timeout_flag_r))
        else $error("software wake wrong");
    // both wake sources raise the wake event
    wake_event_a: assert property (wd_wake || sw_wake |=> stat_r[instr_exec_pkg::IRQ_WAKE])
        else $error("wake event lost");
    // the load-all-ones event is sticky from the cycle after write-back
    ones_event_a: assert property (q4_ones |=> stat_r[instr_exec_pkg::IRQ_ONES])
        else $error("load event lost");
    // an unknown word touches neither flag and never starts sleep
    ill_quiet_a: assert property (q4_ill |=> $stable(power_down_flag_r)
        && $stable(timeout_flag_r) && (state_r == ST_IDLE))
        else $error("unknown word had an effect");
    // reads stall exactly one cycle
    read_wait_a: assert property (rd_now && !rd_wait_r |-> read_wait_s)
        else $error("read wait state wrong");
    // writes never stall
    write_ready_a: assert property (wr_now |-> HREADYOUT_O)
        else $error("write stalled");

endmodule : instr_exec_core

//--- testbench/set_register_and_sleep_instr_test.sv
`timescale 1ns/1ps
module set_register_and_sleep_instr_test;
    ////////////////////////////////////////////////////////////////////////////////
    // stimulus and observation nets
    logic        clk;      // 250 MHz core clock
    logic        nrst;     // synchronous reset, active low
    logic        hsel;     // slave select
    logic [31:0] haddr;    // byte address
    logic [1:0]  htrans;   // transfer kind
    logic        hwrite;   // write strobe
    logic [31:0] hwdata;   // write data
    logic [31:0] hrdata;   // read data
    logic        hready;   // ready, looped back from the slave
    logic        hresp;    // response
    logic        irq;      // interrupt level
    logic        osc_run;  // oscillator running
    logic        sleeping; // core asleep
    int          n_fail;   // mismatches
    int          n_tests;  // comparisons
    logic [31:0] rd;       // last read value
    // short watchdog keeps the timeout wake at (1+1)*256 cycles
    localparam logic [15:0] WD_SIM   = 16'h0001;
    localparam int          WAKE_CYC = 512;
    // instruction words with the cell they must hit and the one they must spare
    localparam logic [15:0] CW [3]   = '{16'h6945, 16'h6822, 16'h6890};
    localparam logic [11:0] HIT [3]  = '{12'h345, 12'h022, 12'hF90};
    localparam logic [11:0] MISS [3] = '{12'h045, 12'h322, 12'h390};

    instr_exec_core #(.WD_LIMIT(WD_SIM)) i_instr_exec_core (
        .CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .IRQ_O(irq),
        .OSC_RUN_O(osc_run), .SLEEP_O(sleeping));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, printed once for every way the run can end
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // compare with case equality so an unknown never matches
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // step edges until ready is sampled high; bounded so a stuck slave ends the run
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t bus ready timeout", $time);
            wrap_up();
        end
    endtask : wait_ready

    ////////////////////////////////////////////////////////////////////////////////
    // one single word transfer: address phase, then data phase
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= instr_exec_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check({31'h0000_0000, hresp}, 32'h0000_0000, "response not okay");
    endtask : bus_xfer

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, a, d, dummy);
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] q);
        bus_xfer(1'b0, a, 32'h0000_0000, q);
    endtask : bus_read

    // data memory goes through the pointer register
    task automatic mem_write(input logic [11:0] a, input logic [7:0] d);
        bus_write(instr_exec_pkg::OFS_DATA_ADDR, {20'h0_0000, a});
        bus_write(instr_exec_pkg::OFS_DATA, {24'h00_0000, d});
    endtask : mem_write

    task automatic mem_read(input logic [11:0] a, output logic [31:0] q);
        bus_write(instr_exec_pkg::OFS_DATA_ADDR, {20'h0_0000, a});
        bus_read(instr_exec_pkg::OFS_DATA, q);
    endtask : mem_read

    // issue a word and let its four phases run out before looking at the result
    task automatic run_instr(input logic [15:0] w);
        bus_write(instr_exec_pkg::OFS_INSTR, {16'h0000, w});
        repeat (6) @(posedge clk);
        bus_read(instr_exec_pkg::OFS_FLAGS, rd);
        check(rd & 32'h0000_0008, 32'h0000_0000, "still busy");
    endtask : run_instr

    ////////////////////////////////////////////////////////////////////////////////
    // free running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // main sequence
    initial begin
        nrst    = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0000_0000;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hwdata  = 32'h0000_0000;
        n_fail  = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // both status flags come out of reset set
        bus_read(instr_exec_pkg::OFS_FLAGS, rd);
        check(rd & 32'h0000_000F, 32'h0000_0003, "reset flags");
        // each addressing mode: bank select, low access half, high access half
        bus_write(instr_exec_pkg::OFS_BANK_SEL, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            mem_write(HIT[i], 8'h5A);
            mem_write(MISS[i], 8'h00);
            run_instr(CW[i]);
            mem_read(HIT[i], rd);
            check(rd, {24'h00_0000, instr_exec_pkg::ALL_ONES}, "target");
            mem_read(MISS[i], rd);
            check(rd, 32'h0000_0000, "other bank touched");
        end
        // completion event: sticky, masked, then unmasked, then cleared
        check({31'h0000_0000, irq}, 32'h0000_0000, "irq while masked");
        bus_read(instr_exec_pkg::OFS_IRQ_STAT, rd);
        check(rd & 32'h0000_0001, 32'h0000_0001, "done status");
        bus_write(instr_exec_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        #1;
        check({31'h0000_0000, irq}, 32'h0000_0001, "irq unmasked");
        bus_write(instr_exec_pkg::OFS_IRQ_STAT, 32'h0000_0001);
        #1;
        check({31'h0000_0000, irq}, 32'h0000_0000, "irq after clear");
        // a word that is neither instruction changes nothing but the status
        run_instr(16'h1234);
        bus_read(instr_exec_pkg::OFS_IRQ_STAT, rd);
        check(rd & 32'h0000_0008, 32'h0000_0008, "illegal status");
        bus_read(8'h3C, rd);
        check(rd, 32'h0000_0000, "unmapped read");
        // first sleep: entry lands exactly after the fourth phase
        bus_write(instr_exec_pkg::OFS_INSTR, {16'h0000, instr_exec_pkg::SLEEP_WORD});
        repeat (3) @(posedge clk);
        #1;
        check({30'h0, osc_run, sleeping}, 32'h0000_0002, "sleep too early");
        @(posedge clk);
        #1;
        check({30'h0, osc_run, sleeping}, 32'h0000_0001, "sleep entry");
        bus_read(instr_exec_pkg::OFS_FLAGS, rd);
        check(rd & 32'h0000_0007, 32'h0000_0006, "asleep flags");
        bus_read(instr_exec_pkg::OFS_WD_COUNT, rd);
        check(rd, 32'h0000_0000, "watchdog count");
        // a stale postscaler would wake the core early
        repeat (WAKE_CYC - 40) @(posedge clk);
        #1;
        check({31'h0000_0000, sleeping}, 32'h0000_0001, "early wake");
        for (int k = 0; k < 80 && sleeping === 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check({30'h0, osc_run, sleeping}, 32'h0000_0002, "watchdog wake");
        bus_read(instr_exec_pkg::OFS_FLAGS, rd);
        check(rd & 32'h0000_0007, 32'h0000_0000, "timeout wake flags");
        // second sleep starts from a cleared timeout flag, so setting it shows
        run_instr(instr_exec_pkg::SLEEP_WORD);
        check(rd & 32'h0000_0007, 32'h0000_0006, "second sleep flags");
        // software wake leaves the timeout flag alone
        bus_write(instr_exec_pkg::OFS_WAKE, 32'h0000_0001);
        repeat (3) @(posedge clk);
        bus_read(instr_exec_pkg::OFS_FLAGS, rd);
        check(rd & 32'h0000_0007, 32'h0000_0002, "software wake flags");
        bus_read(instr_exec_pkg::OFS_IRQ_STAT, rd);
        check(rd & 32'h0000_0006, 32'h0000_0006, "sleep and wake status");
        wrap_up();
    end
endmodule : set_register_and_sleep_instr_test
